// ---- hdl/pow2_divider.v ----
// Divides a tick stream by a power of two chosen at run time.
module pow2_divider #(
	parameter integer W = 5
) (
	input wire sys_clk,
	input wire rst,
	input wire in_tick,
	input wire [2:0] shift,
	output reg out_tick
);
	reg [W-1:0] cnt_q;
	wire [W-1:0] mask = ({{(W-1){1'b0}}, 1'b1} << shift) - {{(W-1){1'b0}}, 1'b1};
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= {W{1'b0}};
			out_tick <= 1'b0;
		end else if (in_tick) begin
			// Ratio changes take effect at once on the running count, so the first period after one may be short.
			out_tick <= ((cnt_q & mask) == mask);
			cnt_q <= ((cnt_q & mask) == mask) ? {W{1'b0}} : cnt_q + {{(W-1){1'b0}}, 1'b1};
		end else begin
			out_tick <= 1'b0;
		end
	end
endmodule

// ---- hdl/ring_tick.v ----
// Programmable tick generator that models a ring oscillator from the system clock.
`include "clock_gen_regs.vh"
module ring_tick #(
	parameter integer DIV = 5
) (
	input wire sys_clk,
	input wire rst,
	input wire run,
	output reg tick
);
	// A tick pulse stands for one period of the modelled oscillator.
	reg [15:0] cnt_q;
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 16'h0000;
			tick <= 1'b0;
		end else if (!run) begin
			cnt_q <= 16'h0000;
			tick <= 1'b0;
		end else if (cnt_q == DIV[15:0] - 16'h0001) begin
			cnt_q <= 16'h0000;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule

// ---- hdl/system_clock_generator.v ----
// Clock generator: source select, CPU and peripheral dividers, slow interval clock, APB registers.
`include "clock_gen_regs.vh"
// Notes on behaviour
// - Source fixed from configuration strap at startup.
// - Fast ring runs nominal 8 MHz, halts on STOP.
// - Resonator oscillation halts on STOP.
// - External clock gated off on STOP.
// - Fast ring frees both oscillator pins.
// - External clock frees second pin only.
// - Interval clock feeds watchdog and 8-bit timer.
// - Slow ring 240 kHz, software stop if allowed.
// - Both divider registers reset to 02H.
// - Divider registers take bit and byte writes.
// - CPU clock ratio from prescaler and divide bit.
// - Prescaler 01H gives peripheral source/2.
// - Prescaler 02H gives peripheral source/4.
// - Shortest instruction takes two CPU periods.
// - Slow mode bit 0 stops; resets 00H.
// - Stop forbidden: writes ignored, keeps running.
module system_clock_generator #(
	parameter integer FAST_DIV = `SYS_CLK_KHZ / `FAST_RING_KHZ,
	parameter integer SLOW_DIV = `SYS_CLK_KHZ / `SLOW_RING_KHZ
) (
	input wire sys_clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [15:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [1:0] source_select,
	input wire soft_stop_allowed,
	input wire stop_exec,
	input wire wake,
	input wire osc_pin_a,
	input wire osc_pin_b,
	output reg source_clock,
	output reg cpu_clock,
	output reg periph_clock,
	output reg min_exec_tick,
	output reg interval_clock,
	output reg pin_a_is_port,
	output reg pin_b_is_port,
	output reg stopped,
	output reg slow_running
);
	// Bit-wise write merge: only enabled, implemented bits change.
	function [7:0] merge;
		input [7:0] old;
		input [7:0] wdat;
		input [7:0] bit_en;
		input [7:0] impl;
		begin
			merge = ((old & ~bit_en) | (wdat & bit_en)) & impl;
		end
	endfunction

	function hit;
		input [15:0] addr;
		input [15:0] reg_addr;
		begin
			hit = (addr == reg_addr);
		end
	endfunction

	// The fast-ring decode is shared by the oscillator enable and the pin release; the second-pin decode serves pin release only.
	function src_is_fast;
		input [1:0] src;
		begin
			src_is_fast = (src == `SRC_FAST_RING);
		end
	endfunction

	function src_frees_b;
		input [1:0] src;
		begin
			src_frees_b = (src == `SRC_FAST_RING) | (src == `SRC_EXTERNAL);
		end
	endfunction

	function [7:0] status_word;
		input [1:0] src;
		input soft_ok;
		input halted;
		input slow_on;
		begin
			status_word = {3'h0, slow_on, halted, soft_ok, src};
		end
	endfunction

	reg [7:0] peripheral_prescaler_q;
	reg [7:0] cpu_clock_divider_q;
	reg [7:0] slow_osc_mode_reg_q;
	reg [1:0] src_q;
	reg soft_ok_q;
	reg strap_done_q;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg ext_prev_q;
	reg [1:0] exec_cnt_q;
	localparam [1:0] ST_RUN = 2'b01;
	localparam [1:0] ST_STOP = 2'b10;
	localparam integer EXEC_LAST = `MIN_EXEC_CPU_PERIODS - 1;

	// Bit enables: pwdata[15:8] when pstrb[1] selects single-bit writes, else byte.
	wire wr_en = psel & penable & pwrite & pstrb[0];
	wire [7:0] bit_en = pstrb[1] ? pwdata[15:8] : 8'hFF;
	wire sel_pre = hit(paddr, `PRESCALER_ADDR);
	wire sel_div = hit(paddr, `DIVIDER_ADDR);
	wire sel_slow = hit(paddr, `SLOW_MODE_ADDR);
	wire sel_stat = hit(paddr, `STATUS_ADDR);
	wire mapped = sel_pre | sel_div | sel_slow | sel_stat;

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	reg [7:0] rd;
	always @* begin
		rd = 8'h00;
		if (sel_pre) begin
			rd = peripheral_prescaler_q;
		end else if (sel_div) begin
			rd = cpu_clock_divider_q;
		end else if (sel_slow) begin
			rd = slow_osc_mode_reg_q;
		end else if (sel_stat) begin
			rd = status_word(src_q, soft_ok_q, stopped, slow_running);
		end
	end
	assign prdata = {24'h000000, rd};

	// Straps are caught by a clocked process on the first edge after reset release.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			src_q <= `SRC_FAST_RING;
			soft_ok_q <= 1'b0;
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			src_q <= source_select;
			soft_ok_q <= soft_stop_allowed;
			strap_done_q <= 1'b1;
		end
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			peripheral_prescaler_q <= `PRESCALER_RESET;
		end else if (wr_en && sel_pre) begin
			peripheral_prescaler_q <= merge(peripheral_prescaler_q, pwdata[7:0], bit_en,
				`PRESCALER_MASK);
		end
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cpu_clock_divider_q <= `DIVIDER_RESET;
		end else if (wr_en && sel_div) begin
			cpu_clock_divider_q <= merge(cpu_clock_divider_q, pwdata[7:0], bit_en,
				`DIVIDER_MASK);
		end
	end

	// Byte write only, and only when the strap permits stopping.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			slow_osc_mode_reg_q <= `SLOW_MODE_RESET;
		end else if (wr_en && sel_slow && soft_ok_q) begin
			slow_osc_mode_reg_q <= pwdata[7:0] & `SLOW_MODE_MASK;
		end
	end

	// Run/stop control; a wake in the same cycle as a stop request wins.
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_RUN: begin
				if (stop_exec && strap_done_q && !wake) begin
					state_d = ST_STOP;
				end
			end
			ST_STOP: begin
				if (wake) begin
					state_d = ST_RUN;
				end
			end
			default: begin
				state_d = ST_RUN;
			end
		endcase
	end

	// No stabilisation wait is modelled after a wake, so the source restarts at once.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end
	wire stop_active = (state_q == ST_STOP);

	wire fast_tick;
	wire slow_tick;
	wire fast_run = strap_done_q & src_is_fast(src_q) & ~stop_active;
	ring_tick #(.DIV(FAST_DIV)) fast_ring (
		.sys_clk(sys_clk),
		.rst(rst),
		.run(fast_run),
		.tick(fast_tick)
	);
	wire slow_run = ~slow_osc_mode_reg_q[`HALT_BIT] | ~soft_ok_q;
	ring_tick #(.DIV(SLOW_DIV)) slow_ring (
		.sys_clk(sys_clk),
		.rst(rst),
		.run(slow_run),
		.tick(slow_tick)
	);

	// Edges on pin A are the resonator or external clock; the pin range is the far end's duty.
	wire pin_rise = osc_pin_a & ~ext_prev_q;
	reg src_tick;
	always @* begin
		case (src_q)
			`SRC_FAST_RING: src_tick = fast_tick;
			`SRC_RESONATOR: src_tick = pin_rise & ~stop_active;
			`SRC_EXTERNAL: src_tick = pin_rise & ~stop_active;
			default: src_tick = 1'b0;
		endcase
		if (!strap_done_q) begin
			src_tick = 1'b0;
		end
	end

	// CPU ratio as a power of two; prohibited codes fall back to the slowest ratio.
	wire [2:0] sel3 = {peripheral_prescaler_q[1:0], cpu_clock_divider_q[`DIVIDE_BIT]};
	reg [2:0] cpu_shift;
	reg [2:0] per_shift;
	always @* begin
		case (sel3)
			3'h0: cpu_shift = 3'h0;
			3'h2: cpu_shift = 3'h1;
			3'h1: cpu_shift = 3'h2;
			3'h4: cpu_shift = 3'h2;
			3'h3: cpu_shift = 3'h3;
			3'h5: cpu_shift = 3'h4;
			default: cpu_shift = 3'h4;
		endcase
	end

	always @* begin
		case (peripheral_prescaler_q[1:0])
			2'h0: per_shift = 3'h0;
			2'h1: per_shift = 3'h1;
			2'h2: per_shift = 3'h2;
			default: per_shift = 3'h2;
		endcase
	end

	wire cpu_tick;
	wire per_tick;
	pow2_divider #(.W(5)) cpu_div (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_tick(src_tick),
		.shift(cpu_shift),
		.out_tick(cpu_tick)
	);
	pow2_divider #(.W(5)) per_div (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_tick(src_tick),
		.shift(per_shift),
		.out_tick(per_tick)
	);

	// The first edge after reset is masked by the strap wait, so a high pin gives no false edge.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ext_prev_q <= 1'b0;
		end else begin
			ext_prev_q <= osc_pin_a;
		end
	end

	// Clock outputs are registered pulses so consumers see clean one-cycle strobes.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			source_clock <= 1'b0;
			cpu_clock <= 1'b0;
			periph_clock <= 1'b0;
			interval_clock <= 1'b0;
		end else begin
			source_clock <= src_tick;
			cpu_clock <= cpu_tick;
			periph_clock <= per_tick;
			interval_clock <= slow_tick;
		end
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			exec_cnt_q <= 2'h0;
			min_exec_tick <= 1'b0;
		end else begin
			min_exec_tick <= 1'b0;
			if (cpu_tick) begin
				if (exec_cnt_q == EXEC_LAST[1:0]) begin
					exec_cnt_q <= 2'h0;
					min_exec_tick <= 1'b1;
				end else begin
					exec_cnt_q <= exec_cnt_q + 2'h1;
				end
			end
		end
	end

	// Pins stay claimed by the oscillator until the straps are known.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pin_a_is_port <= 1'b0;
			pin_b_is_port <= 1'b0;
		end else begin
			pin_a_is_port <= strap_done_q & src_is_fast(src_q);
			pin_b_is_port <= strap_done_q & src_frees_b(src_q);
		end
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stopped <= 1'b0;
			slow_running <= 1'b0;
		end else begin
			stopped <= stop_active;
			slow_running <= slow_run;
		end
	end
endmodule

// ---- include/clock_gen_regs.vh ----
// Register map, field positions, reset values and clock-source codes of the clock generator.
`ifndef CLOCK_GEN_REGS_VH
`define CLOCK_GEN_REGS_VH
`define PRESCALER_ADDR 16'hFFF3
`define DIVIDER_ADDR 16'hFFFB
`define SLOW_MODE_ADDR 16'hFF58
`define STATUS_ADDR 16'hFF5C
`define PRESCALER_RESET 8'h02
`define DIVIDER_RESET 8'h02
`define SLOW_MODE_RESET 8'h00
`define PRESCALER_MASK 8'h03
`define DIVIDER_MASK 8'h02
`define SLOW_MODE_MASK 8'h01
`define DIVIDE_BIT 1
`define HALT_BIT 0
`define SRC_FAST_RING 2'h0
`define SRC_RESONATOR 2'h1
`define SRC_EXTERNAL 2'h2
`define FAST_RING_KHZ 8000
`define SLOW_RING_KHZ 240
`define SYS_CLK_KHZ 40000
`define MIN_EXEC_CPU_PERIODS 2
`define EXT_MIN_KHZ 500
`define EXT_MAX_KHZ 10000
`endif

// ---- test/ext_osc.sv ----
// Far-side clock source that drives the first oscillator pin.
module ext_osc #(
	parameter int HALF = 3
) (
	input wire logic sys_clk,
	input wire logic run,
	output logic osc_pin_a = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	// A period of 2 * HALF cycles at 40 MHz must stay within 500 kHz to 10 MHz.
	always @(posedge sys_clk) begin
		if (!run) begin
			osc_pin_a <= 1'b0;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			osc_pin_a <= ~osc_pin_a;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// ---- test/system_clock_generator_chk.sv ----
// Checker for bus replies, stop gating, pin release and the slow clock.
`include "clock_gen_regs.vh"
module system_clock_generator_chk (
	input wire sys_clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire [15:0] paddr,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire [1:0] source_select,
	input wire soft_stop_allowed,
	input wire source_clock,
	input wire interval_clock,
	input wire pin_a_is_port,
	input wire pin_b_is_port,
	input wire stopped,
	input wire slow_running
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] up_q;
	wire mapped = paddr == `PRESCALER_ADDR || paddr == `DIVIDER_ADDR ||
		paddr == `SLOW_MODE_ADDR || paddr == `STATUS_ADDR;
	// Straps reach the pins a few cycles after reset, so pin checks wait for this count.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			up_q <= 2'h0;
		end else if (up_q != 2'h3) begin
			up_q <= up_q + 2'h1;
		end
	end
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	bad_addr_a: assert property (psel && penable && !mapped |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	upper_zero_a: assert property (psel |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	stop_quiet_a: assert property (stopped && $past(stopped, 3) |-> !source_clock)
		else $error("source clock runs while stopped");
	pulse_one_a: assert property (source_clock |=> !source_clock)
		else $error("source clock pulse too long");
	pin_a_a: assert property (up_q == 2'h3 |-> pin_a_is_port == (source_select == `SRC_FAST_RING))
		else $error("first pin release wrong");
	pin_b_a: assert property (up_q == 2'h3 |-> pin_b_is_port ==
		(source_select == `SRC_FAST_RING || source_select == `SRC_EXTERNAL))
		else $error("second pin release wrong");
	halt_gate_a: assert property ($fell(slow_running) |-> soft_stop_allowed)
		else $error("slow oscillator stopped though forbidden");
	interval_run_a: assert property (interval_clock |-> slow_running || $past(slow_running))
		else $error("interval clock from stopped oscillator");
endmodule

// ---- test/tb_system_clock_generator.sv ----
// Testbench for the clock generator: registers, ratios, stop and straps.
`include "clock_gen_regs.vh"
module tb_system_clock_generator;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, er;
	logic soft_stop_allowed = 1, stop_exec = 0, wake = 0, ext_on = 0;
	logic [1:0] source_select = 0;
	logic [3:0] pstrb = 0;
	logic [15:0] paddr = 0;
	logic [31:0] pwdata = 0, rd;
	wire [31:0] prdata;
	wire pready, pslverr, source_clock, cpu_clock, periph_clock, min_exec_tick;
	wire interval_clock, pin_a_is_port, pin_b_is_port, stopped, slow_running, osc_pin_a;
	wire [4:0] outs = {min_exec_tick, interval_clock, periph_clock, cpu_clock, source_clock};
	int fails = 0, total_checks = 0, cyc = 0, idle_n = 0;
	int pre[7] = '{0, 1, 0, 2, 1, 2, 3};
	int dv[7] = '{0, 0, 1, 0, 1, 1, 0};
	int sh[7] = '{0, 1, 2, 2, 3, 4, 4};
	int ps[7] = '{0, 1, 0, 2, 1, 2, 2};
	system_clock_generator #(.FAST_DIV(2), .SLOW_DIV(4)) i_dut (.sys_clk, .rst, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .source_select,
		.soft_stop_allowed, .stop_exec, .wake, .osc_pin_a, .osc_pin_b(1'b0), .source_clock,
		.cpu_clock, .periph_clock, .min_exec_tick, .interval_clock, .pin_a_is_port,
		.pin_b_is_port, .stopped, .slow_running);
	ext_osc #(.HALF(3)) i_osc (.sys_clk, .run(ext_on), .osc_pin_a);
	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (fails == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, logic [15:0] a, logic [31:0] d, logic [3:0] s);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, 4'h0);
		check(rd, exp);
	endtask
	// The first pulse after a ratio change may be short, so two pulses pass before counting.
	task automatic per(input int k, input int exp);
		int n;
		n = 0;
		repeat (2) @(posedge sys_clk iff outs[k] === 1'b1);
		do begin
			n++;
			@(posedge sys_clk);
		end while (outs[k] !== 1'b1);
		check(n, exp);
	endtask
	task automatic halt(input int p);
		int n;
		n = 0;
		@(posedge sys_clk);
		stop_exec <= 1'b1;
		@(posedge sys_clk);
		stop_exec <= 1'b0;
		repeat (8) @(posedge sys_clk);
		check(stopped, 1'b1);
		repeat (40) @(posedge sys_clk) n += (source_clock !== 1'b0);
		check(n, 0);
		wake <= 1'b1;
		@(posedge sys_clk);
		wake <= 1'b0;
		per(0, p);
	endtask
	task automatic boot(input logic [1:0] s, input logic ok);
		rst <= 1'b1;
		source_select <= s;
		soft_stop_allowed <= ok;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask
	initial begin
		boot(`SRC_FAST_RING, 1'b1);
		rchk(`PRESCALER_ADDR, 32'h2);
		rchk(`DIVIDER_ADDR, 32'h2);
		rchk(`SLOW_MODE_ADDR, 32'h0);
		rchk(16'h0000, 32'h0);
		check(er, 1'b1);
		check({pin_a_is_port, pin_b_is_port}, 2'h3);
		rchk(`STATUS_ADDR, 32'h14);
		apb(1'b1, `PRESCALER_ADDR, 32'hFF, 4'h1);
		rchk(`PRESCALER_ADDR, 32'h3);
		apb(1'b1, `PRESCALER_ADDR, 32'h0200, 4'h3);
		rchk(`PRESCALER_ADDR, 32'h1);
		apb(1'b1, `DIVIDER_ADDR, 32'hFF, 4'h1);
		rchk(`DIVIDER_ADDR, 32'h2);
		apb(1'b1, `DIVIDER_ADDR, 32'hFF00, 4'h3);
		rchk(`DIVIDER_ADDR, 32'h0);
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, `PRESCALER_ADDR, pre[i], 4'h1);
			apb(1'b1, `DIVIDER_ADDR, {16'h0, 8'h02, 6'h0, dv[i][0], 1'b0}, 4'h3);
			per(1, 2 << sh[i]);
			per(2, 2 << ps[i]);
			per(4, 4 << sh[i]);
		end
		per(3, 4);
		apb(1'b1, `SLOW_MODE_ADDR, 32'h1, 4'h1);
		rchk(`SLOW_MODE_ADDR, 32'h1);
		check(slow_running, 1'b0);
		apb(1'b1, `SLOW_MODE_ADDR, 32'h0, 4'h1);
		per(3, 4);
		halt(2);
		boot(`SRC_EXTERNAL, 1'b0);
		ext_on <= 1'b1;
		check({pin_a_is_port, pin_b_is_port}, 2'h1);
		rchk(`STATUS_ADDR, 32'h12);
		per(0, 6);
		apb(1'b1, `SLOW_MODE_ADDR, 32'h1, 4'h1);
		rchk(`SLOW_MODE_ADDR, 32'h0);
		check(slow_running, 1'b1);
		halt(6);
		boot(`SRC_RESONATOR, 1'b1);
		check({pin_a_is_port, pin_b_is_port}, 2'h0);
		halt(6);
		boot(2'h3, 1'b1);
		check({pin_a_is_port, pin_b_is_port}, 2'h0);
		rchk(`STATUS_ADDR, 32'h17);
		repeat (40) @(posedge sys_clk) idle_n += (source_clock !== 1'b0);
		check(idle_n, 0);
		complete_run();
	end
endmodule
bind system_clock_generator system_clock_generator_chk i_chk (
	.sys_clk(sys_clk),
	.rst(rst),
	.psel(psel),
	.penable(penable),
	.paddr(paddr),
	.prdata(prdata),
	.pslverr(pslverr),
	.source_select(source_select),
	.soft_stop_allowed(soft_stop_allowed),
	.source_clock(source_clock),
	.interval_clock(interval_clock),
	.pin_a_is_port(pin_a_is_port),
	.pin_b_is_port(pin_b_is_port),
	.stopped(stopped),
	.slow_running(slow_running)
);
